// File: core/mode_reg_pkg.sv
/*
 * constants for the converter's mode register and its three-wire serial port:
 * register selects, field positions, reset value, transfer lengths and states.
 * assumes the serial clock idles high and the host drives data on its falling edge.
 */
package mode_reg_pkg;
    // register select codes carried in the command byte
    localparam logic [2:0] SEL_STATUS = 3'h0;
    localparam logic [2:0] SEL_MODE = 3'h1;
    localparam logic [2:0] SEL_DATA = 3'h3;

    // command byte layout
    localparam int CMD_BITS = 8;
    localparam int CMD_READ_POS = 6;
    localparam int CMD_SEL_LSB = 3;

    // mode register
    localparam int MODE_WIDTH = 24;
    localparam logic [23:0] MODE_RESET = 24'h080060;
    localparam int OP_MODE_LSB = 21;
    localparam int STATUS_APPEND_POS = 20;
    localparam int CLK_SRC_HI_POS = 19;
    localparam int CLK_SRC_LO_POS = 18;
    localparam int FIXED_ZERO_POS = 14;
    localparam int PARITY_EN_POS = 13;

    // clock source encodings
    localparam logic [1:0] CLK_XTAL = 2'h0;
    localparam logic [1:0] CLK_EXT = 2'h1;
    localparam logic [1:0] CLK_INT = 2'h2;

    // data and status words
    localparam int DATA_WIDTH = 24;
    localparam int STATUS_WIDTH = 8;
    localparam int TX_WIDTH = DATA_WIDTH + STATUS_WIDTH;
    localparam logic [7:0] STATUS_RESET = 8'h80;

    typedef enum logic [1:0] {
        ST_CMD,
        ST_WRITE,
        ST_READ,
        ST_IDLE
    } port_state_t;
endpackage : mode_reg_pkg

// File: core/serial_bit_if.sv
/*
 * carrier between the serial pin shifter and the register logic.
 * assumes both ends run on clk_sys.
 */
`timescale 1ns/10ps
interface serial_bit_if;
    logic frame_active;
    logic frame_start;
    logic rx_strobe;
    logic rx_bit;
    logic tx_advance;
    logic tx_bit;

    modport pins (
        output frame_active,
        output frame_start,
        output rx_strobe,
        output rx_bit,
        output tx_advance,
        input tx_bit
    );

    modport regs (
        input frame_active,
        input frame_start,
        input rx_strobe,
        input rx_bit,
        input tx_advance,
        output tx_bit
    );
endinterface : serial_bit_if

// File: core/serial_pin_shifter.sv
/*
 * synchronises the serial pins to clk_sys and turns their edges into bit strobes;
 * drives the serial data out pin from a flop updated on each falling serial edge while cs_n is low.
 * assumes the serial clock is well below clk_sys / 4 so every edge is seen.
 */
`timescale 1ns/10ps
module serial_pin_shifter (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // register side
    serial_bit_if.pins bits
);
    logic [1:0] sclk_sync, cs_sync, din_sync;
    logic sclk_prev, cs_prev;
    logic [1:0] next_sclk_sync, next_cs_sync, next_din_sync;
    logic next_sclk_prev, next_cs_prev, next_dout;

    always_comb begin
        next_sclk_sync = {sclk_sync[0], sclk};
        next_cs_sync = {cs_sync[0], cs_n};
        next_din_sync = {din_sync[0], din};
        next_sclk_prev = sclk_sync[1];
        next_cs_prev = cs_sync[1];
        next_dout = dout;
        if (bits.tx_advance) begin
            next_dout = bits.tx_bit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sclk_sync <= 2'h3;
            cs_sync <= 2'h3;
            din_sync <= 2'h0;
            sclk_prev <= 1'b1;
            cs_prev <= 1'b1;
            dout <= 1'b1;
        end else begin
            sclk_sync <= next_sclk_sync;
            cs_sync <= next_cs_sync;
            din_sync <= next_din_sync;
            sclk_prev <= next_sclk_prev;
            cs_prev <= next_cs_prev;
            dout <= next_dout;
        end
    end

    assign bits.frame_active = ~cs_sync[1];
    assign bits.frame_start = cs_prev & ~cs_sync[1];
    // host samples on rising edge, so that is where we take its data
    assign bits.rx_strobe = ~cs_sync[1] & ~sclk_prev & sclk_sync[1];
    assign bits.rx_bit = din_sync[1];
    assign bits.tx_advance = ~cs_sync[1] & sclk_prev & ~sclk_sync[1];
endmodule : serial_pin_shifter

// File: core/mode_register_bank.sv
/*
 * mode register of a sigma-delta converter behind its three-wire serial port,
 * with the command decode, data/status readback and the not-ready and parity flags.
 * assumes the converter datapath supplies results and channel as clk_sys pulses.
 */
`timescale 1ns/10ps
module mode_register_bank (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // serial port pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // converter datapath
    input wire logic result_valid,
    input wire logic [23:0] result_data,
    input wire logic result_err,
    input wire logic result_noref,
    input wire logic [3:0] result_chan,
    input wire logic update_soon,
    // configuration outputs
    output logic [2:0] op_mode_sel,
    output logic status_append_en,
    output logic clk_src_sel_hi,
    output logic clk_src_sel_lo,
    output logic parity_check_en,
    output logic [23:0] mode_word,
    output logic modulator_reset,
    output logic not_ready,
    // master clock pin b drive, enable low while driving
    output logic master_clk_pin_b_oe_n,
    output logic internal_osc_en
);
    serial_bit_if bits ();

    serial_pin_shifter u_pins (
        .clk_sys(clk_sys),
        .reset(reset),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .dout(dout),
        .bits(bits)
    );

    mode_reg_pkg::port_state_t state, next_state;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [23:0] rx_sr, next_rx_sr;
    logic [31:0] tx_sr, next_tx_sr;
    logic [2:0] cmd_sel, next_cmd_sel;
    logic [23:0] mode_reg, next_mode_reg;
    logic [23:0] data_reg, next_data_reg;
    logic [7:0] status_reg, next_status_reg;
    logic next_modulator_reset, next_osc_en, next_oe_n;
    logic [7:0] cmd_byte;
    logic mode_write_done, data_read_done;

    // fields of the stored mode word
    function automatic logic [1:0] clk_field(input logic [23:0] w);
        clk_field = {w[mode_reg_pkg::CLK_SRC_HI_POS], w[mode_reg_pkg::CLK_SRC_LO_POS]};
    endfunction : clk_field

    function automatic logic [5:0] read_len(input logic [2:0] sel, input logic [23:0] mode);
        if (sel == mode_reg_pkg::SEL_STATUS) begin
            read_len = 6'(mode_reg_pkg::STATUS_WIDTH);
        end else if (sel == mode_reg_pkg::SEL_DATA
                     && mode[mode_reg_pkg::STATUS_APPEND_POS]) begin
            read_len = 6'(mode_reg_pkg::TX_WIDTH);
        end else begin
            read_len = 6'(mode_reg_pkg::MODE_WIDTH);
        end
    endfunction : read_len

    assign cmd_byte = {rx_sr[6:0], bits.rx_bit};
    assign bits.tx_bit = tx_sr[31];

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rx_sr = rx_sr;
        next_tx_sr = tx_sr;
        next_cmd_sel = cmd_sel;
        mode_write_done = 1'b0;
        data_read_done = 1'b0;
        if (!bits.frame_active || bits.frame_start) begin
            next_state = mode_reg_pkg::ST_CMD;
            next_bit_cnt = 6'h00;
        end else begin
            case (state)
                mode_reg_pkg::ST_CMD: begin
                    if (bits.rx_strobe) begin
                        next_rx_sr = {rx_sr[22:0], bits.rx_bit};
                        next_bit_cnt = bit_cnt + 6'h01;
                        if (bit_cnt == 6'(mode_reg_pkg::CMD_BITS - 1)) begin
                            next_bit_cnt = 6'h00;
                            next_cmd_sel = cmd_byte[mode_reg_pkg::CMD_SEL_LSB +: 3];
                            if (cmd_byte[mode_reg_pkg::CMD_READ_POS]) begin
                                next_state = mode_reg_pkg::ST_READ;
                                case (cmd_byte[mode_reg_pkg::CMD_SEL_LSB +: 3])
                                    mode_reg_pkg::SEL_STATUS: begin
                                        next_tx_sr = {status_reg, 24'h000000};
                                    end
                                    mode_reg_pkg::SEL_MODE: begin
                                        next_tx_sr = {mode_reg, 8'h00};
                                    end
                                    mode_reg_pkg::SEL_DATA: begin
                                        next_tx_sr = {data_reg, status_reg};
                                    end
                                    default: begin
                                        next_tx_sr = 32'h00000000;
                                    end
                                endcase
                            end else begin
                                next_state = mode_reg_pkg::ST_WRITE;
                            end
                        end
                    end
                end
                mode_reg_pkg::ST_WRITE: begin
                    if (bits.rx_strobe) begin
                        next_rx_sr = {rx_sr[22:0], bits.rx_bit};
                        next_bit_cnt = bit_cnt + 6'h01;
                        if (bit_cnt == 6'(mode_reg_pkg::MODE_WIDTH - 1)) begin
                            next_state = mode_reg_pkg::ST_IDLE;
                            mode_write_done = (cmd_sel == mode_reg_pkg::SEL_MODE);
                        end
                    end
                end
                mode_reg_pkg::ST_READ: begin
                    // host has taken the bit on show; move the next one up before the fall
                    if (bits.rx_strobe) begin
                        next_tx_sr = {tx_sr[30:0], 1'b0};
                        next_bit_cnt = bit_cnt + 6'h01;
                        if (bit_cnt == read_len(cmd_sel, mode_reg) - 6'h01) begin
                            next_state = mode_reg_pkg::ST_IDLE;
                            data_read_done = (cmd_sel == mode_reg_pkg::SEL_DATA);
                        end
                    end
                end
                default: begin
                    next_state = mode_reg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        next_mode_reg = mode_reg;
        next_data_reg = data_reg;
        next_status_reg = status_reg;
        next_modulator_reset = mode_write_done;
        if (mode_write_done) begin
            next_mode_reg = {rx_sr[22:0], bits.rx_bit};
            next_mode_reg[mode_reg_pkg::FIXED_ZERO_POS] = 1'b0;
        end
        if (result_valid) begin
            next_data_reg = result_data;
            next_status_reg[6:0] = {result_err, result_noref,
                mode_reg[mode_reg_pkg::PARITY_EN_POS] & (^result_data), result_chan};
        end
        // any set beats a same-cycle clear; a mode write restarts conversion and wins
        if (data_read_done || update_soon) begin
            next_status_reg[7] = 1'b1;
        end else if (result_valid) begin
            next_status_reg[7] = 1'b0;
        end
        if (mode_write_done) begin
            next_status_reg[7] = 1'b1;
        end
        // crystal drives pin b; external clock and internal oscillator leave it undriven
        next_oe_n = (clk_field(next_mode_reg) != mode_reg_pkg::CLK_XTAL);
        next_osc_en = (clk_field(next_mode_reg) == mode_reg_pkg::CLK_INT);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= mode_reg_pkg::ST_CMD;
            bit_cnt <= 6'h00;
            rx_sr <= 24'h000000;
            tx_sr <= 32'hffffffff;
            cmd_sel <= 3'h0;
            mode_reg <= mode_reg_pkg::MODE_RESET;
            data_reg <= 24'h000000;
            status_reg <= mode_reg_pkg::STATUS_RESET;
            modulator_reset <= 1'b1;
            master_clk_pin_b_oe_n <= 1'b1;
            internal_osc_en <= 1'b1;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            rx_sr <= next_rx_sr;
            tx_sr <= next_tx_sr;
            cmd_sel <= next_cmd_sel;
            mode_reg <= next_mode_reg;
            data_reg <= next_data_reg;
            status_reg <= next_status_reg;
            modulator_reset <= next_modulator_reset;
            master_clk_pin_b_oe_n <= next_oe_n;
            internal_osc_en <= next_osc_en;
        end
    end

    // field outputs are straight slices of the mode register flops
    assign op_mode_sel = mode_reg[mode_reg_pkg::OP_MODE_LSB +: 3];
    assign status_append_en = mode_reg[mode_reg_pkg::STATUS_APPEND_POS];
    assign clk_src_sel_hi = mode_reg[mode_reg_pkg::CLK_SRC_HI_POS];
    assign clk_src_sel_lo = mode_reg[mode_reg_pkg::CLK_SRC_LO_POS];
    assign parity_check_en = mode_reg[mode_reg_pkg::PARITY_EN_POS];
    assign mode_word = mode_reg;
    assign not_ready = status_reg[7];
endmodule : mode_register_bank

// File: verification/mode_register_bank_chk.sv
/*
 * concurrent checks on the mode register bank, seen from its top ports only.
 * assumes one clk_sys domain with a synchronous active-high reset.
 */
`timescale 1ns/10ps
module mode_register_bank_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // datapath events
    input wire logic result_valid,
    input wire logic update_soon,
    // configuration outputs
    input wire logic [2:0] op_mode_sel,
    input wire logic status_append_en,
    input wire logic clk_src_sel_hi,
    input wire logic clk_src_sel_lo,
    input wire logic parity_check_en,
    input wire logic [23:0] mode_word,
    input wire logic modulator_reset,
    input wire logic not_ready,
    input wire logic master_clk_pin_b_oe_n,
    input wire logic internal_osc_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // derived outputs change on the same edge as the word; compare only once it is stable
    sequence s_settled;
        $stable(mode_word);
    endsequence
    sequence s_new_result;
        result_valid && !update_soon;
    endsequence
    chk_field_map: assert property (s_settled |->
        {op_mode_sel, status_append_en, clk_src_sel_hi, clk_src_sel_lo} == mode_word[23:18])
        else $error("mode fields differ from mode word");
    chk_parity_map: assert property (s_settled |-> parity_check_en == mode_word[13])
        else $error("parity enable differs from mode word");
    chk_fixed_zero: assert property (mode_word[14] == 1'b0)
        else $error("fixed bit of mode word is set");
    chk_pin_drive: assert property (s_settled |->
        master_clk_pin_b_oe_n == (mode_word[19:18] != 2'h0))
        else $error("pin b drive does not follow clock source");
    chk_osc_enable: assert property (s_settled |->
        internal_osc_en == (mode_word[19:18] == 2'h2))
        else $error("oscillator enable does not follow clock source");
    chk_write_restart: assert property (!$stable(mode_word) |-> ##[0:2] modulator_reset)
        else $error("mode write without modulator restart");
    chk_write_busy: assert property (modulator_reset |-> ##[0:1] not_ready)
        else $error("mode write without not-ready");
    // a mode write ending in the same cycle shows as the restart pulse and keeps the flag
    chk_result_clear: assert property (s_new_result |=> !not_ready || modulator_reset)
        else $error("new result left not-ready set");
    chk_soon_set: assert property (update_soon |=> not_ready)
        else $error("update warning left not-ready clear");
endmodule : mode_register_bank_chk

bind mode_register_bank mode_register_bank_chk i_mode_register_bank_chk (
    .clk_sys, .reset, .result_valid, .update_soon, .op_mode_sel, .status_append_en,
    .clk_src_sel_hi, .clk_src_sel_lo, .parity_check_en, .mode_word, .modulator_reset,
    .not_ready, .master_clk_pin_b_oe_n, .internal_osc_en);

// File: verification/host_model.sv
/*
 * host side of the three-wire serial port: one command byte, one transfer per frame.
 * assumes the device samples din on rising sclk and shifts dout on falling sclk.
 */
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clk_sys,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    // generous half period, far above what the pin synchronisers need
    localparam int HALF = 10;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b1;
    end
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] wd,
        output logic [31:0] rd);
        logic [31:0] w;
        logic b;
        w = wd;
        rd = 32'h0;
        if (!cmd[6] && cmd[5:3] == mode_reg_pkg::SEL_MODE) w[14] = 1'b0;
        @(posedge clk_sys) cs_n <= 1'b0;
        repeat (HALF) @(posedge clk_sys);
        for (int i = 0; i < 8 + n; i++) begin
            b = (i < 8) ? cmd[7 - i] : w[n + 7 - i];
            sclk <= 1'b0;
            din <= b;
            repeat (HALF) @(posedge clk_sys);
            sclk <= 1'b1;
            if (i >= 8) rd = {rd[30:0], dout};
            repeat (HALF) @(posedge clk_sys);
        end
        // a released line must not keep showing the last bit
        cs_n <= 1'b1;
        din <= ~din;
        repeat (HALF) @(posedge clk_sys);
    endtask : xfer
endmodule : host_model

// File: verification/mode_register_bank_tb.sv
/*
 * self-checking bench for the mode register bank, driving it through the host model.
 * assumes 250 MHz clk_sys and the command byte layout of the design package.
 */
`timescale 1ns/10ps
module mode_register_bank_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic sclk, cs_n, din, dout;
    logic result_valid = 1'b0;
    logic [23:0] result_data = 24'h0;
    logic result_err = 1'b0;
    logic result_noref = 1'b0;
    logic [3:0] result_chan = 4'h0;
    logic update_soon = 1'b0;
    logic [2:0] op_mode_sel;
    logic status_append_en, clk_src_sel_hi, clk_src_sel_lo, parity_check_en;
    logic [23:0] mode_word;
    logic modulator_reset, not_ready, master_clk_pin_b_oe_n, internal_osc_en;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    // clock sources 00, 01, 10 in turn
    localparam logic [23:0] WORDS [3] = '{24'ha12345, 24'h3523a5, 24'hd8a5a5};

    always #2 clk_sys = ~clk_sys;

    mode_register_bank i_mode_register_bank (.clk_sys, .reset, .sclk, .cs_n, .din, .dout,
        .result_valid, .result_data, .result_err, .result_noref, .result_chan, .update_soon,
        .op_mode_sel, .status_append_en, .clk_src_sel_hi, .clk_src_sel_lo, .parity_check_en,
        .mode_word, .modulator_reset, .not_ready, .master_clk_pin_b_oe_n, .internal_osc_en);
    host_model i_host_model (.clk_sys, .sclk, .cs_n, .din, .dout);

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one result or update-soon pulse, then let the flag update land before any check
    task automatic pulse(input logic [23:0] d, input logic [5:0] st, input logic soon);
        @(posedge clk_sys);
        result_valid <= !soon;
        update_soon <= soon;
        result_data <= d;
        {result_err, result_noref, result_chan} <= st;
        @(posedge clk_sys);
        result_valid <= 1'b0;
        update_soon <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : pulse

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] rd;
        logic [23:0] w;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(mode_word, mode_reg_pkg::MODE_RESET);
        chk({not_ready, master_clk_pin_b_oe_n, internal_osc_en}, 3'h7);
        i_host_model.xfer(8'h48, 24, 32'h0, rd);
        chk(rd, {8'h0, mode_reg_pkg::MODE_RESET});
        $display("test reset done");
        foreach (WORDS[k]) begin
            w = WORDS[k];
            i_host_model.xfer(8'h08, 24, {8'h0, w}, rd);
            #1;
            chk(not_ready, 1'b1);
            chk({op_mode_sel, status_append_en}, w[23:20]);
            chk({clk_src_sel_hi, clk_src_sel_lo}, w[19:18]);
            chk(parity_check_en, w[13]);
            chk(master_clk_pin_b_oe_n, w[19:18] != 2'h0);
            chk(internal_osc_en, w[19:18] == 2'h2);
            i_host_model.xfer(8'h48, 24, 32'h0, rd);
            chk(rd, {8'h0, w});
        end
        $display("test mode write done");
        pulse(24'h000007, 6'h25, 1'b0);
        chk(not_ready, 1'b0);
        i_host_model.xfer(8'h58, 32, 32'h0, rd);
        chk(rd, {24'h000007, 8'h55});
        chk(not_ready, 1'b1);
        i_host_model.xfer(8'h40, 8, 32'h0, rd);
        chk(rd, 32'hd5);
        pulse(24'h000003, 6'h1a, 1'b0);
        i_host_model.xfer(8'h40, 8, 32'h0, rd);
        chk(rd, 32'h2a);
        pulse(24'h0, 6'h0, 1'b1);
        chk(not_ready, 1'b1);
        $display("test status done");
        i_host_model.xfer(8'h18, 24, 32'h00ffffff, rd);
        chk(mode_word, 24'hd8a5a5);
        i_host_model.xfer(8'h08, 24, 32'h0, rd);
        pulse(24'h00000f, 6'h0, 1'b0);
        i_host_model.xfer(8'h58, 24, 32'h0, rd);
        chk(rd, 32'h00000f);
        $display("test select and append done");
        give_verdict();
    end
endmodule : mode_register_bank_tb
